// ### src/fsq_pkg.sv
// Constants for the host-side flash operation sequencer.
// Assumes a 40 MHz system clock and an asynchronous two-bank NOR flash.
package fsq_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  // Pin timings as printed, in their own units
  localparam int READ_LATENCY_NS = 30;
  localparam int ACCESS_NS = 90;
  localparam int RESET_LOW_US = 2;
  localparam int RESET_RECOVERY_NS = 150;
  localparam int WRITE_PULSE_NS = 60;
  localparam int WRITE_HIGH_NS = 30;
  localparam int BUSY_DELAY_NS = 90;
  localparam int SUSPEND_US = 15;
  localparam int PROGRAM_MAX_MS = 80;
  localparam int ERASE_MAX_MS = 600;
  // Least times round up
  localparam int READ_LAT_CYC =
    (READ_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int RECOVERY_CYC =
    (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CYC = (BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  localparam longint PROGRAM_CYC = longint'(PROGRAM_MAX_MS) * 1000 * CLK_MHZ;
  localparam longint ERASE_CYC = longint'(ERASE_MAX_MS) * 1000 * CLK_MHZ;
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'hd0;
  localparam logic [7:0] CMD_READ_LOCK = 8'h71;
  // Status bit positions
  localparam int SR_OVERPROG = 3;
  localparam int SR_PROG_FAIL = 4;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_SUSPEND = 6;
  localparam int SR_READY = 7;
  // Address layout: bank select is the top three address bits
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [2:0] BANK1_HI = 3'h0;
  // User operations
  typedef enum logic [2:0] {
    FSQ_OP_READ    = 3'b000,
    FSQ_OP_PROGRAM = 3'b001,
    FSQ_OP_ERASE   = 3'b010,
    FSQ_OP_SUSPEND = 3'b011,
    FSQ_OP_RESUME  = 3'b100,
    FSQ_OP_LOCK_RD = 3'b101
  } fsq_op_t;
  // Outcome codes
  typedef enum logic [2:0] {
    FSQ_RES_OK       = 3'b000,
    FSQ_RES_SEQ_ERR  = 3'b001,
    FSQ_RES_ERASE    = 3'b010,
    FSQ_RES_PROGRAM  = 3'b011,
    FSQ_RES_BLOCK    = 3'b100,
    FSQ_RES_REFUSED  = 3'b101,
    FSQ_RES_TIMEOUT  = 3'b110,
    FSQ_RES_SUSPEND  = 3'b111
  } fsq_res_t;
endpackage

// ### src/fsq_bus_cycle.sv
// One flash bus cycle: a strobed write or a gated read.
// Assumes pins feed an asynchronous flash; data input pre-synchronised.
`timescale 1ns/1ps
`default_nettype none
module fsq_bus_cycle (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // Request
  input  wire logic                         start,
  input  wire logic                         is_write,
  input  wire logic [fsq_pkg::ADDR_W-1:0]   addr,
  input  wire logic [fsq_pkg::DATA_W-1:0]   wdata,
  input  wire logic [7:0]                   pre_wait,
  output logic                              done,
  output logic [fsq_pkg::DATA_W-1:0]        rdata,
  // Pins
  input  wire logic [fsq_pkg::DATA_W-1:0]   dq_sync,
  output logic                              ce_n,
  output logic                              we_n,
  output logic                              oe_n,
  output logic [fsq_pkg::ADDR_W-1:0]        a,
  output logic [fsq_pkg::DATA_W-1:0]        dq_o,
  output logic                              dq_oe
);
  typedef enum logic [1:0] {
    FSQ_BC_IDLE = 2'b00,
    FSQ_BC_PRE  = 2'b01,
    FSQ_BC_ACT  = 2'b10,
    FSQ_BC_POST = 2'b11
  } fsq_bc_t;

  fsq_bc_t    st_q;
  logic [7:0] cnt_q;
  logic       wr_q;
  wire        cnt_zero = (cnt_q == 8'h00);
  // Read holds gate long enough for access plus two sync stages
  wire [7:0]  act_len = wr_q ? 8'(fsq_pkg::WR_PULSE_CYC)
                             : 8'(fsq_pkg::ACCESS_CYC + 2);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q  <= FSQ_BC_IDLE;
      cnt_q <= 8'h00;
      wr_q  <= 1'b0;
      done  <= 1'b0;
      rdata <= '0;
      ce_n  <= 1'b1;
      we_n  <= 1'b1;
      oe_n  <= 1'b1;
      a     <= '0;
      dq_o  <= '0;
      dq_oe <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (st_q)
        FSQ_BC_IDLE:
          if (start)
          begin
            wr_q  <= is_write;
            a     <= addr;
            dq_o  <= wdata;
            cnt_q <= pre_wait;
            st_q  <= FSQ_BC_PRE;
          end
        FSQ_BC_PRE:
          if (cnt_zero)
          begin
            ce_n  <= 1'b0;
            we_n  <= ~wr_q;
            oe_n  <= wr_q;
            dq_oe <= wr_q;
            cnt_q <= act_len;
            st_q  <= FSQ_BC_ACT;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        FSQ_BC_ACT:
          if (cnt_zero)
          begin
            rdata <= dq_sync;
            ce_n  <= 1'b1;
            we_n  <= 1'b1;
            oe_n  <= 1'b1;
            cnt_q <= 8'(fsq_pkg::WR_HIGH_CYC);
            st_q  <= FSQ_BC_POST;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        FSQ_BC_POST:
          if (cnt_zero)
          begin
            dq_oe <= 1'b0;
            done  <= 1'b1;
            st_q  <= FSQ_BC_IDLE;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        default:
          st_q <= FSQ_BC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### src/fsq_host.sv
// Host-side sequencer for a two-bank asynchronous NOR flash.
// Assumes ready_busy_n and dq come straight from the device pins.
`timescale 1ns/1ps
`default_nettype none
module fsq_host #(
  parameter longint PROGRAM_TIMEOUT = fsq_pkg::PROGRAM_CYC,
  parameter longint ERASE_TIMEOUT   = fsq_pkg::ERASE_CYC
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // User command port
  input  wire logic                         op_valid,
  input  wire fsq_pkg::fsq_op_t             op_code,
  input  wire logic [fsq_pkg::ADDR_W-1:0]   op_addr,
  input  wire logic [fsq_pkg::DATA_W-1:0]   op_wdata,
  output logic                              op_ready,
  output logic                              res_valid,
  output fsq_pkg::fsq_res_t                 res_code,
  output logic [fsq_pkg::DATA_W-1:0]        res_rdata,
  output logic [7:0]                        res_status,
  // Flash pins
  output logic                              reset_powerdown_n,
  output logic                              ce_n,
  output logic                              we_n,
  output logic                              oe_n,
  output logic [fsq_pkg::ADDR_W-1:0]        a,
  output logic [fsq_pkg::DATA_W-1:0]        dq_o,
  output logic                              dq_oe,
  input  wire logic [fsq_pkg::DATA_W-1:0]   dq_i,
  input  wire logic                         ready_busy_n
);
  typedef enum logic [3:0] {
    FSQ_RESET    = 4'h0,
    FSQ_RECOVER  = 4'h1,
    FSQ_IDLE     = 4'h2,
    FSQ_CMD1     = 4'h3,
    FSQ_CMD2     = 4'h4,
    FSQ_BUSYWAIT = 4'h5,
    FSQ_POLLCMD  = 4'h6,
    FSQ_POLLRD   = 4'h7,
    FSQ_CLEAR    = 4'h8,
    FSQ_RDCMD    = 4'h9,
    FSQ_RDDATA   = 4'ha,
    FSQ_DONE     = 4'hb
  } fsq_state_t;

  // Outcome of a finished status word
  function automatic fsq_pkg::fsq_res_t judge(input logic [7:0] sr);
    if (sr[fsq_pkg::SR_PROG_FAIL] && sr[fsq_pkg::SR_ERASE_FAIL])
      judge = fsq_pkg::FSQ_RES_SEQ_ERR;
    else if (sr[fsq_pkg::SR_ERASE_FAIL])
      judge = fsq_pkg::FSQ_RES_ERASE;
    else if (sr[fsq_pkg::SR_PROG_FAIL])
      judge = fsq_pkg::FSQ_RES_PROGRAM;
    else if (sr[fsq_pkg::SR_OVERPROG])
      judge = fsq_pkg::FSQ_RES_BLOCK;
    else
      judge = fsq_pkg::FSQ_RES_OK;
  endfunction

  // Two-stage synchronisers for pin inputs
  logic [fsq_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic                       rb_s1_q, rb_s2_q;
  always_ff @(posedge clk)
  begin
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
    rb_s1_q <= ready_busy_n;
    rb_s2_q <= rb_s1_q;
  end

  fsq_state_t                 st_q;
  logic [31:0]                cnt_q;
  fsq_pkg::fsq_op_t           op_q;
  logic [fsq_pkg::ADDR_W-1:0] addr_q;
  logic [fsq_pkg::DATA_W-1:0] wdata_q;
  logic                       bc_start, bc_write, bc_done;
  logic [fsq_pkg::ADDR_W-1:0] bc_addr;
  logic [fsq_pkg::DATA_W-1:0] bc_wdata, bc_rdata;
  logic [7:0]                 bc_pre;
  logic                       busy_q;

  wire in_bank1 = (op_addr[fsq_pkg::ADDR_W-1 -: 3] == fsq_pkg::BANK1_HI);
  wire bad_prog = (op_code == fsq_pkg::FSQ_OP_PROGRAM) && !in_bank1;
  wire two_cycle = (op_q == fsq_pkg::FSQ_OP_PROGRAM) ||
                   (op_q == fsq_pkg::FSQ_OP_ERASE);
  wire [7:0] cmd1 =
    (op_q == fsq_pkg::FSQ_OP_PROGRAM) ? fsq_pkg::CMD_WORD_PROGRAM :
    (op_q == fsq_pkg::FSQ_OP_ERASE)   ? fsq_pkg::CMD_ERASE :
    (op_q == fsq_pkg::FSQ_OP_SUSPEND) ? fsq_pkg::CMD_SUSPEND :
    (op_q == fsq_pkg::FSQ_OP_RESUME)  ? fsq_pkg::CMD_RESUME :
    (op_q == fsq_pkg::FSQ_OP_LOCK_RD) ? fsq_pkg::CMD_READ_LOCK :
                                        fsq_pkg::CMD_READ_ARRAY;
  wire [31:0] op_limit =
    (op_q == fsq_pkg::FSQ_OP_ERASE)   ? 32'(ERASE_TIMEOUT) :
    (op_q == fsq_pkg::FSQ_OP_SUSPEND) ? 32'(fsq_pkg::SUSPEND_CYC) :
                                        32'(PROGRAM_TIMEOUT);
  wire [7:0] sr = bc_rdata[7:0];
  wire engine_idle = sr[fsq_pkg::SR_READY];
  wire halted = engine_idle || sr[fsq_pkg::SR_SUSPEND];

  // Bus cycle issue, decoded from the state
  assign bc_start = (st_q == FSQ_CMD1 || st_q == FSQ_CMD2 ||
                     st_q == FSQ_POLLCMD || st_q == FSQ_POLLRD ||
                     st_q == FSQ_CLEAR || st_q == FSQ_RDCMD ||
                     st_q == FSQ_RDDATA) && !busy_q;
  assign bc_write = (st_q != FSQ_POLLRD) && (st_q != FSQ_RDDATA);
  // Suspend, resume, status go to the target bank address
  assign bc_addr = addr_q;
  assign bc_wdata =
    (st_q == FSQ_CMD1)    ? {8'h00, cmd1} :
    (st_q == FSQ_CMD2)    ? ((op_q == fsq_pkg::FSQ_OP_ERASE) ?
                             {8'h00, fsq_pkg::CMD_CONFIRM} : wdata_q) :
    (st_q == FSQ_POLLCMD) ? {8'h00, fsq_pkg::CMD_READ_STATUS} :
    (st_q == FSQ_CLEAR)   ? {8'h00, fsq_pkg::CMD_CLEAR_STATUS} :
                            {8'h00, fsq_pkg::CMD_READ_ARRAY};
  // Read after a read-array or lock command waits out the latency
  assign bc_pre = (st_q == FSQ_RDDATA) ?
                  8'(fsq_pkg::READ_LAT_CYC) : 8'h00;

  assign op_ready = (st_q == FSQ_IDLE);

  fsq_bus_cycle u_cycle (
    .clk      (clk),
    .reset    (reset),
    .start    (bc_start),
    .is_write (bc_write),
    .addr     (bc_addr),
    .wdata    (bc_wdata),
    .pre_wait (bc_pre),
    .done     (bc_done),
    .rdata    (bc_rdata),
    .dq_sync  (dq_s2_q),
    .ce_n     (ce_n),
    .we_n     (we_n),
    .oe_n     (oe_n),
    .a        (a),
    .dq_o     (dq_o),
    .dq_oe    (dq_oe)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q <= FSQ_RESET;
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
      op_q <= fsq_pkg::FSQ_OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      reset_powerdown_n <= 1'b0;
      res_valid <= 1'b0;
      res_code <= fsq_pkg::FSQ_RES_OK;
      res_rdata <= '0;
      res_status <= 8'h00;
    end
    else
    begin
      res_valid <= 1'b0;
      if (bc_start)
        busy_q <= 1'b1;
      else if (bc_done)
        busy_q <= 1'b0;
      case (st_q)
        FSQ_RESET:
          if (cnt_q == 32'(fsq_pkg::RESET_LOW_CYC))
          begin
            reset_powerdown_n <= 1'b1;
            cnt_q <= 32'h0;
            st_q <= FSQ_RECOVER;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        FSQ_RECOVER:
          if (cnt_q == 32'(fsq_pkg::RECOVERY_CYC))
            st_q <= FSQ_IDLE;
          else
            cnt_q <= cnt_q + 32'h1;
        FSQ_IDLE:
          if (op_valid)
          begin
            op_q <= op_code;
            addr_q <= op_addr;
            wdata_q <= op_wdata;
            if (bad_prog)
            begin
              res_code <= fsq_pkg::FSQ_RES_REFUSED;
              st_q <= FSQ_DONE;
            end
            else if (op_code == fsq_pkg::FSQ_OP_READ)
              st_q <= FSQ_RDCMD;
            else
              st_q <= FSQ_CMD1;
          end
        FSQ_CMD1:
          if (bc_done)
          begin
            cnt_q <= 32'h0;
            if (two_cycle)
              st_q <= FSQ_CMD2;
            else if (op_q == fsq_pkg::FSQ_OP_LOCK_RD)
              st_q <= FSQ_RDDATA;
            else if (op_q == fsq_pkg::FSQ_OP_SUSPEND)
              st_q <= FSQ_POLLCMD;
            else
            begin
              res_code <= fsq_pkg::FSQ_RES_OK;
              st_q <= FSQ_DONE;
            end
          end
        FSQ_CMD2:
          if (bc_done)
          begin
            cnt_q <= 32'h0;
            st_q <= FSQ_BUSYWAIT;
          end
        FSQ_BUSYWAIT:
        begin
          // Give ready_busy_n time to fall before trusting it
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q > 32'(fsq_pkg::BUSY_CYC + 2) && rb_s2_q)
            st_q <= FSQ_POLLCMD;
          else if (cnt_q >= op_limit)
            st_q <= FSQ_POLLCMD;
        end
        FSQ_POLLCMD:
          if (bc_done)
            st_q <= FSQ_POLLRD;
        FSQ_POLLRD:
          if (bc_done)
          begin
            res_status <= sr;
            if (halted)
            begin
              res_code <= (op_q == fsq_pkg::FSQ_OP_SUSPEND) ?
                          fsq_pkg::FSQ_RES_SUSPEND : judge(sr);
              st_q <= FSQ_CLEAR;
            end
            else if (cnt_q >= op_limit)
            begin
              res_code <= fsq_pkg::FSQ_RES_TIMEOUT;
              st_q <= FSQ_DONE;
            end
            else
            begin
              cnt_q <= cnt_q + 32'h10;
              st_q <= FSQ_POLLCMD;
            end
          end
          else
            cnt_q <= cnt_q + 32'h1;
        FSQ_CLEAR:
          if (bc_done)
            st_q <= FSQ_DONE;
        FSQ_RDCMD:
          if (bc_done)
            st_q <= FSQ_RDDATA;
        FSQ_RDDATA:
          if (bc_done)
          begin
            res_rdata <= bc_rdata;
            res_code <= fsq_pkg::FSQ_RES_OK;
            st_q <= FSQ_DONE;
          end
        FSQ_DONE:
        begin
          res_valid <= 1'b1;
          st_q <= FSQ_IDLE;
        end
        default:
          st_q <= FSQ_IDLE;
      endcase
    end
  end
  // Device-side lockout is invisible here; a timeout reports it.
endmodule
`default_nettype wire

// ### testbench/fsq_host_asserts.sv
// Pin and result checks for the flash sequencer.
// Bound to fsq_host; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fsq_host_asserts #(
  parameter longint PROGRAM_TIMEOUT = 0,
  parameter longint ERASE_TIMEOUT   = 0
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // User side
  input wire logic                       op_valid,
  input wire fsq_pkg::fsq_op_t           op_code,
  input wire logic [fsq_pkg::ADDR_W-1:0] op_addr,
  input wire logic [fsq_pkg::DATA_W-1:0] op_wdata,
  input wire logic                       op_ready,
  input wire logic                       res_valid,
  input wire fsq_pkg::fsq_res_t          res_code,
  input wire logic [fsq_pkg::DATA_W-1:0] res_rdata,
  input wire logic [7:0]                 res_status,
  // Flash pins
  input wire logic                       reset_powerdown_n,
  input wire logic                       ce_n,
  input wire logic                       we_n,
  input wire logic                       oe_n,
  input wire logic [fsq_pkg::ADDR_W-1:0] a,
  input wire logic [fsq_pkg::DATA_W-1:0] dq_o,
  input wire logic                       dq_oe,
  input wire logic [fsq_pkg::DATA_W-1:0] dq_i,
  input wire logic                       ready_busy_n
);
  logic [7:0] low_q;
  logic [7:0] up_q;
  logic [2:0] bank_q;
  wire        wr_cmd = !we_n && dq_oe;
  wire [7:0]  cmd = dq_o[7:0];
  // Saturating, so long idle stretches never wrap
  always_ff @(posedge clk)
  begin
    // Cleared in reset so the count is never unknown at the first release
    low_q <= (reset || reset_powerdown_n) ? 8'h00
                                          : low_q + {7'h00, low_q != 8'hff};
    up_q  <= !reset_powerdown_n ? 8'h00 : up_q + {7'h00, up_q != 8'hff};
    if (wr_cmd && (cmd == 8'h40 || cmd == 8'h20))
      bank_q <= a[19:17];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_rp_low_time: assert property (
    $rose(reset_powerdown_n) |-> low_q >= 8'h50) else $error("rp low short");
  chk_rp_recovery: assert property (
    ($fell(ce_n) || $fell(we_n)) |-> reset_powerdown_n && up_q >= 8'h06)
    else $error("strobe too soon after rp high");
  chk_rp_held: assert property (
    !reset_powerdown_n |-> ce_n && we_n && oe_n) else $error("strobe in rp low");
  chk_word_bank: assert property (
    wr_cmd && cmd == 8'h40 |-> a[19:17] == fsq_pkg::BANK1_HI)
    else $error("word program outside first bank");
  chk_susp_bank: assert property (
    wr_cmd && (cmd == 8'hb0 || cmd == 8'hd0) |-> a[19:17] == bank_q)
    else $error("suspend or resume bank wrong");
  chk_read_latency: assert property (
    $rose(we_n) && (cmd == 8'hff || cmd == 8'h71) |-> oe_n [*2])
    else $error("read too soon after read command");
  chk_access_time: assert property (
    $fell(oe_n) |-> !oe_n [*4]) else $error("read gate too short");
  chk_seq_err: assert property (
    res_valid && res_code == fsq_pkg::FSQ_RES_SEQ_ERR |-> res_status[5:4] == 2'h3)
    else $error("sequence error without both flags");
  chk_erase_fail: assert property (
    res_valid && res_code == fsq_pkg::FSQ_RES_ERASE |-> res_status[5:4] == 2'h2)
    else $error("erase fail code mismatch");
  chk_prog_fail: assert property (
    res_valid && res_code == fsq_pkg::FSQ_RES_PROGRAM |-> res_status[5:4] == 2'h1)
    else $error("program fail code mismatch");
  chk_block_err: assert property (
    res_valid && res_code == fsq_pkg::FSQ_RES_BLOCK |-> res_status[5:3] == 3'h1)
    else $error("block error code mismatch");
  cov_suspend: cover property (res_valid && res_code == fsq_pkg::FSQ_RES_SUSPEND);
  cov_timeout: cover property (res_valid && res_code == fsq_pkg::FSQ_RES_TIMEOUT);
  cov_refused: cover property (res_valid && res_code == fsq_pkg::FSQ_RES_REFUSED);
endmodule
bind fsq_host fsq_host_asserts #(.PROGRAM_TIMEOUT(PROGRAM_TIMEOUT),
  .ERASE_TIMEOUT(ERASE_TIMEOUT)) u_chk (.clk(clk), .reset(reset),
  .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
  .op_wdata(op_wdata), .op_ready(op_ready), .res_valid(res_valid),
  .res_code(res_code), .res_rdata(res_rdata), .res_status(res_status),
  .reset_powerdown_n(reset_powerdown_n), .ce_n(ce_n), .we_n(we_n),
  .oe_n(oe_n), .a(a), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
  .ready_busy_n(ready_busy_n));
`default_nettype wire

// ### testbench/fsq_flash_model.sv
// Behavioural two-bank flash seen from its pins.
// Assumes the bench clock paces the engine; busy length set by the bench.
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_model (
  // Engine pacing and test controls
  input  wire logic                       clk,
  input  wire logic [2:0]                 fail_bits,
  input  wire logic [15:0]                busy_len,
  // Flash pins
  input  wire logic                       reset_powerdown_n,
  input  wire logic                       ce_n,
  input  wire logic                       we_n,
  input  wire logic                       oe_n,
  input  wire logic [fsq_pkg::ADDR_W-1:0] a,
  input  wire logic [fsq_pkg::DATA_W-1:0] dq_o,
  output logic [fsq_pkg::DATA_W-1:0]      dq_i,
  output logic                            ready_busy_n
);
  logic [7:0]  cmd_q;
  logic [7:0]  wd_q;
  logic [19:0] wa_q;
  logic [1:0]  mode_q;
  logic        busy_q;
  logic        susp_q;
  logic        we_q;
  logic [2:0]  flag_q;
  logic [2:0]  bank_q;
  logic [15:0] cnt_q;
  logic [15:0] last_q;
  wire [7:0]   sr = {!busy_q, susp_q, flag_q, 3'b000};
  wire         drv = !ce_n && !oe_n;
  wire         own = busy_q && a[19:17] == bank_q;
  wire [15:0]  val = (mode_q == 2'd1 || own) ? {8'h00, sr} :
                     (mode_q == 2'd2) ? 16'h0040 : a[15:0] ^ 16'h5a5a;
  // Released bus shows the inverse, never a stale match
  assign dq_i = drv ? val : ~last_q;
  assign ready_busy_n = !busy_q;
  always @(posedge clk)
  begin
    we_q <= we_n;
    if (drv)
      last_q <= val;
    if (!we_n && !ce_n)
    begin
      wa_q <= a;
      wd_q <= dq_o[7:0];
    end
    if (!reset_powerdown_n)
    begin
      // Stands in for supply lockout: engine back to read mode
      busy_q <= 1'b0;
      susp_q <= 1'b0;
      flag_q <= 3'b000;
      mode_q <= 2'd0;
      cmd_q <= 8'h00;
      last_q <= 16'h0000;
    end
    else if (!we_q && we_n)
    begin
      if (cmd_q == 8'h40 || (cmd_q == 8'h20 && wd_q == 8'hd0))
      begin
        busy_q <= 1'b1;
        cnt_q <= busy_len;
        bank_q <= wa_q[19:17];
        cmd_q <= 8'h00;
        mode_q <= 2'd1;
      end
      else
      begin
        cmd_q <= (wd_q == 8'h40 || wd_q == 8'h20) ? wd_q : 8'h00;
        case (wd_q)
          8'h70: mode_q <= 2'd1;
          8'h50: flag_q <= 3'b000;
          8'hff: mode_q <= 2'd0;
          8'h71: mode_q <= 2'd2;
          8'hb0: if (busy_q) {busy_q, susp_q, mode_q} <= 4'b0101;
          8'hd0: if (susp_q) {busy_q, susp_q} <= 2'b10;
          default: ;
        endcase
      end
    end
    else if (busy_q)
    begin
      cnt_q <= cnt_q - 16'h1;
      if (cnt_q == 16'h1)
      begin
        busy_q <= 1'b0;
        flag_q <= fail_bits;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_fsq_host.sv
// Self-checking bench for the flash sequencer.
// Assumes fsq_flash_model on the pins; program and erase timeouts shortened to 2000 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_fsq_host;
  logic                       clk;
  logic                       reset;
  logic                       op_valid;
  fsq_pkg::fsq_op_t           op_code;
  logic [fsq_pkg::ADDR_W-1:0] op_addr;
  logic [fsq_pkg::DATA_W-1:0] op_wdata;
  logic                       op_ready;
  logic                       res_valid;
  fsq_pkg::fsq_res_t          res_code;
  logic [15:0]                res_rdata;
  logic [7:0]                 res_status;
  logic                       rp_n;
  logic                       ce_n;
  logic                       we_n;
  logic                       oe_n;
  logic                       dq_oe;
  logic                       rb_n;
  logic [19:0]                a;
  logic [15:0]                dq_o;
  logic [15:0]                dq_i;
  logic [2:0]                 fail_bits;
  logic [15:0]                busy_len;
  int                         err_count = 0;
  int                         check_count = 0;
  int                         cyc = 0;
  int                         we_falls = 0;
  int                         w0;
  logic [2:0]        fv [6] = '{3'b000, 3'b110, 3'b010, 3'b001, 3'b100, 3'b000};
  fsq_pkg::fsq_res_t ev [6] = '{fsq_pkg::FSQ_RES_OK, fsq_pkg::FSQ_RES_SEQ_ERR,
    fsq_pkg::FSQ_RES_PROGRAM, fsq_pkg::FSQ_RES_BLOCK, fsq_pkg::FSQ_RES_ERASE,
    fsq_pkg::FSQ_RES_OK};
  fsq_host #(.PROGRAM_TIMEOUT(2000), .ERASE_TIMEOUT(2000)) u_dut (
    .clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_ready(op_ready),
    .res_valid(res_valid), .res_code(res_code), .res_rdata(res_rdata),
    .res_status(res_status), .reset_powerdown_n(rp_n), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .a(a), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i), .ready_busy_n(rb_n));
  fsq_flash_model u_mem (.clk(clk), .fail_bits(fail_bits),
    .busy_len(busy_len), .reset_powerdown_n(rp_n), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .a(a), .dq_o(dq_o), .dq_i(dq_i), .ready_busy_n(rb_n));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One user operation, waiting a bounded time for its result
  task automatic run(input fsq_pkg::fsq_op_t op, input logic [19:0] ad,
                     input logic [15:0] wd);
    int n;
    n = 0;
    op_code <= op;
    op_addr <= ad;
    op_wdata <= wd;
    op_valid <= 1'b1;
    @(posedge clk);
    while (op_ready !== 1'b1)
      @(posedge clk);
    op_valid <= 1'b0;
    while (res_valid !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    check("result wait", 16'(n < 5000), 16'h1);
  endtask
  always @(negedge we_n)
    we_falls++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = fsq_pkg::FSQ_OP_READ;
    op_addr = 20'h00000;
    op_wdata = 16'h0000;
    fail_bits = 3'b000;
    busy_len = 16'd50;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    while (op_ready !== 1'b1 && cyc < 500)
      @(posedge clk);
    check("power-up wait", 16'(cyc >= 88), 16'h1);
    run(fsq_pkg::FSQ_OP_READ, 20'h21357, 16'h0000);
    check("read bank2", res_rdata, 16'h1357 ^ 16'h5a5a);
    run(fsq_pkg::FSQ_OP_LOCK_RD, 20'h08000, 16'h0000);
    check("lock read", res_rdata, 16'h0040);
    for (int i = 0; i < 6; i++)
    begin
      fail_bits <= fv[i];
      run((i < 4) ? fsq_pkg::FSQ_OP_PROGRAM : fsq_pkg::FSQ_OP_ERASE,
          20'h04000 + 20'(i), 16'h1234);
      check("outcome", 16'(res_code), 16'(ev[i]));
      check("status", 16'(res_status), {8'h00, 2'b10, fv[i], 3'b000});
    end
    w0 = we_falls;
    run(fsq_pkg::FSQ_OP_PROGRAM, 20'h20010, 16'h1234);
    check("bank2 word", 16'(res_code), 16'(fsq_pkg::FSQ_RES_REFUSED));
    check("bank2 pins", 16'(we_falls - w0), 16'h0);
    fail_bits <= 3'b000;
    busy_len <= 16'd3000;
    run(fsq_pkg::FSQ_OP_PROGRAM, 20'h00100, 16'h1234);
    check("long op", 16'(res_code), 16'(fsq_pkg::FSQ_RES_TIMEOUT));
    run(fsq_pkg::FSQ_OP_SUSPEND, 20'h00100, 16'h0000);
    check("suspend", 16'(res_code), 16'(fsq_pkg::FSQ_RES_SUSPEND));
    check("suspend flag", 16'(res_status[6]), 16'h1);
    run(fsq_pkg::FSQ_OP_RESUME, 20'h00100, 16'h0000);
    check("resume", 16'(res_code), 16'(fsq_pkg::FSQ_RES_OK));
    check("bank1 busy", 16'(rb_n), 16'h0);
    run(fsq_pkg::FSQ_OP_READ, 20'h30246, 16'h0000);
    check("bg read", 16'(res_code), 16'(fsq_pkg::FSQ_RES_OK));
    check("bg data", res_rdata, 16'h0246 ^ 16'h5a5a);
    conclude();
  end
endmodule
`default_nettype wire
